// File: common/tec_pkg.sv
// Purpose: constants and types for the timer event and control register block
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are byte addresses within the timer window
`default_nettype none
package tec_pkg;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 8;
	// register offsets
	localparam logic [5:0] OFS_EVENT_ROUTING = 6'h03;
	localparam logic [5:0] OFS_CHANNEL_MODE = 6'h04;
	localparam logic [5:0] OFS_IRQ_LEVEL_A = 6'h06;
	localparam logic [5:0] OFS_IRQ_LEVEL_B = 6'h07;
	localparam logic [5:0] OFS_RUN_CLEAR = 6'h08;
	localparam logic [5:0] OFS_RUN_SET = 6'h09;
	localparam logic [5:0] OFS_CLOCK_SOURCE = 6'h00;
	// event routing field layout
	localparam int unsigned EVENT_ACTION_SELECT_LSB = 5;
	localparam int unsigned EVENT_DELAY_BIT = 4;
	localparam int unsigned EVENT_SOURCE_SELECT_LSB = 0;
	// run command field layout
	localparam int unsigned STOP_BIT = 5;
	localparam int unsigned CMD_LSB = 2;
	localparam int unsigned UPDATE_LOCK_BIT = 1;
	localparam int unsigned DIR_BIT = 0;
	// writable masks
	localparam logic [7:0] RUN_MASK = 8'h23;
	localparam logic [7:0] IRQA_MASK = 8'h3F;
	localparam logic [7:0] CLOCK_SOURCE_SELECT_MASK = 8'h0F;
	// reset values
	localparam logic [7:0] RUN_RESET = 8'h20;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// offset of a channel from the base event channel
	localparam logic [2:0] CH_B_OFS = 3'h1;
	localparam logic [2:0] CH_C_OFS = 3'h2;
	localparam logic [2:0] CH_D_OFS = 3'h3;
	localparam logic [3:0] CLOCK_SOURCE_SELECT_OFF = 4'h0;

	typedef enum logic [2:0] {
		ACT_NONE = 3'b000,
		ACT_FAULT_ONE = 3'b001,
		ACT_FAULT_TWO = 3'b010,
		ACT_EXTERNAL_DIRECTION_COUNT = 3'b011,
		ACT_QUADRATURE_DECODE_ACTION = 3'b100,
		ACT_RESTART = 3'b101,
		ACT_PWF = 3'b110,
		ACT_RSVD = 3'b111
	} tec_action_t;

	typedef enum logic [1:0] {
		CMD_NONE = 2'b00,
		CMD_UPDATE = 2'b01,
		CMD_RESTART = 2'b10,
		CMD_HARD_RESET = 2'b11
	} tec_cmd_t;

	typedef enum logic [1:0] {
		MODE_INTERNAL = 2'b00,
		MODE_OUTPUT_COMP = 2'b01,
		MODE_CAPTURE = 2'b10,
		MODE_BOTH = 2'b11
	} tec_ccmode_t;

	// restart condition source
	typedef enum logic [2:0] {
		RST_SW = 3'b000,
		RST_SW_FAULT = 3'b001,
		RST_QUADRATURE_DECODE_ACTION = 3'b010,
		RST_EVENT = 3'b011,
		RST_NONE = 3'b100
	} tec_restart_t;
endpackage
`default_nettype wire

// File: rtl/tec_ctrl.sv
// Purpose: event routing, channel mode, irq level and run/command registers
// Assumes: one clock, strobes synchronous, read data one cycle after strobe
// Notes: counter datapath lives outside; this block steers it
//
// Contract
// RULE_01 - event delay bit delays selected events by exactly one clock
// RULE_02 - source select 0000 none, 0001-0111 reserved, 1nnn picks base n
// RULE_03 - channels A..D default to event channels n..n+3 modulo 8
// RULE_04 - fault modes and pulse-width capture override channel sourcing
// RULE_05 - restart source follows event action; action 111 reserved
// RULE_06 - plain capture: action 000, source chosen, channel mode capture
// RULE_07 - two-bit mode per channel, D top to A bottom, four settings
// RULE_08 - modes 00 and 11 only with conditional-capture fault operation
// RULE_09 - irq level A: restart 5:4, error 3:2, overflow 1:0
// RULE_10 - irq level B: one two-bit field per channel, D top
// RULE_11 - set alias sets ones, clear alias clears ones, zeros untouched
// RULE_12 - both alias addresses read the same current contents
// RULE_13 - stop bit halts counter and events; resets to one
// RULE_14 - clearing stop resumes counting unless clock source is off
// RULE_15 - command: none, update, restart, hard reset only when off
// RULE_16 - command field is a write strobe and reads zero
// RULE_17 - update lock blocks buffer to active copies
// RULE_18 - update lock ignored while input capture enabled
// RULE_19 - direction reads 0 counting up, 1 down; hardware drives it
// RULE_20 - software writes to direction are accepted
// RULE_21 - software writes zeros to reserved bits
// RULE_22 - event action decodes eight settings, 111 reserved
// RULE_23 - clock source 0000 is off; nonzero starts counter
// RULE_24 - irq level 00 disables, 01/10/11 low/medium/high
// RULE_25 - alias writes act within one cycle and beat hardware direction
`timescale 1ns/10ps
`default_nettype none
module tec_ctrl
	import tec_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [tec_pkg::ADDR_W-1:0] addr_i,
	input wire logic [tec_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [tec_pkg::DATA_W-1:0] rdata_o,
	input wire logic [7:0] event_ch_i,
	input wire logic fault_input_a_i,
	input wire logic fault_input_b_i,
	input wire logic hw_dir_set_i,
	input wire logic hw_dir_value_i,
	input wire logic counter_off_i,
	input wire logic capture_any_i,
	output logic [3:0] cc_event_o,
	output logic restart_event_o,
	output logic [2:0] restart_src_o,
	output logic [2:0] event_action_o,
	output logic [7:0] channel_mode_o,
	output logic count_run_o,
	output logic events_enable_o,
	output logic count_dir_o,
	output logic update_allow_o,
	output logic cmd_update_o,
	output logic cmd_restart_o,
	output logic cmd_hard_reset_o,
	output logic [1:0] restart_irq_level_o,
	output logic [1:0] error_irq_level_o,
	output logic [1:0] overflow_irq_level_o,
	output logic [7:0] channel_irq_level_o
);
	import tec_pkg::*;

	typedef struct packed {
		logic [7:0] routing;
		logic [7:0] ch_mode;
		logic [7:0] irq_a;
		logic [7:0] irq_b;
		logic [7:0] run;
		logic [3:0] clk_sel;
		logic [7:0] ev_dly;
		logic [3:0] cc_ev;
		logic rst_ev;
		logic [1:0] cmd;
		logic [7:0] rdata;
	} tec_state_t;

	tec_state_t s_q;
	tec_state_t s_d;

	logic [2:0] base_ch;
	logic src_on;
	logic [7:0] ev_sel;
	logic ev_base;
	logic [3:0] cc_src;
	logic [2:0] rsrc;
	tec_action_t act;
	logic [7:0] rd_mux;
	logic [1:0] wcmd;

	// source select: only 1nnn picks a channel, reserved codes act as none
	always_comb
	begin
		act = tec_action_t'(s_q.routing[EVENT_ACTION_SELECT_LSB +: 3]);
		base_ch = s_q.routing[EVENT_SOURCE_SELECT_LSB +: 3];
		src_on = s_q.routing[EVENT_SOURCE_SELECT_LSB + 3]; // see RULE_02
		// one flop delay for cascaded carry, chosen for all channels by the one delay bit
		ev_sel = s_q.routing[EVENT_DELAY_BIT] ? s_q.ev_dly : event_ch_i; // see RULE_01
		ev_base = src_on & ev_sel[base_ch];
	end

	// per-channel sourcing by action
	always_comb
	begin
		cc_src[0] = ev_base; // see RULE_03
		cc_src[1] = src_on & ev_sel[base_ch + CH_B_OFS];
		cc_src[2] = src_on & ev_sel[base_ch + CH_C_OFS];
		cc_src[3] = src_on & ev_sel[base_ch + CH_D_OFS];
		rsrc = RST_SW;
		unique case (act) // see RULE_22
			ACT_NONE, ACT_EXTERNAL_DIRECTION_COUNT: rsrc = RST_SW; // see RULE_05
			ACT_FAULT_ONE:
			begin
				cc_src[0] = fault_input_a_i | fault_input_b_i; // see RULE_04
				cc_src[1] = fault_input_a_i | fault_input_b_i;
				rsrc = RST_SW_FAULT;
			end
			ACT_FAULT_TWO:
			begin
				cc_src[0] = fault_input_a_i; // see RULE_04
				cc_src[2] = fault_input_a_i;
				cc_src[1] = fault_input_b_i;
				cc_src[3] = fault_input_b_i;
				rsrc = RST_SW_FAULT;
			end
			ACT_QUADRATURE_DECODE_ACTION: rsrc = RST_QUADRATURE_DECODE_ACTION;
			ACT_RESTART: rsrc = RST_EVENT;
			ACT_PWF:
			begin
				cc_src[1] = ev_base; // see RULE_04
				rsrc = RST_EVENT;
			end
			ACT_RSVD:
			begin
				cc_src = 4'h0; // reserved action routes nothing
				rsrc = RST_NONE;
			end
		endcase
	end

	// read mux; both alias addresses return run contents
	always_comb
	begin
		unique case (addr_i)
			OFS_CLOCK_SOURCE: rd_mux = {4'h0, s_q.clk_sel};
			OFS_EVENT_ROUTING: rd_mux = s_q.routing;
			OFS_CHANNEL_MODE: rd_mux = s_q.ch_mode;
			OFS_IRQ_LEVEL_A: rd_mux = s_q.irq_a;
			OFS_IRQ_LEVEL_B: rd_mux = s_q.irq_b;
			OFS_RUN_CLEAR, OFS_RUN_SET: rd_mux = s_q.run; // see RULE_12
			default: rd_mux = ZERO_BYTE; // unmapped reads zero
		endcase
	end

	// next state
	always_comb
	begin
		s_d = s_q;
		s_d.ev_dly = event_ch_i;
		s_d.cc_ev = cc_src;
		s_d.rst_ev = (rsrc == RST_EVENT) & ev_base;
		s_d.cmd = CMD_NONE;
		s_d.rdata = rd_i ? rd_mux : ZERO_BYTE;
		wcmd = wdata_i[CMD_LSB +: 2];
		// hardware direction first so a same-cycle write overrides it
		if (hw_dir_set_i)
		begin
			s_d.run[DIR_BIT] = hw_dir_value_i; // see RULE_19
		end
		if (wr_i)
		begin
			unique case (addr_i)
				OFS_CLOCK_SOURCE: s_d.clk_sel = wdata_i[3:0] & CLOCK_SOURCE_SELECT_MASK[3:0];
				OFS_EVENT_ROUTING: s_d.routing = wdata_i;
				OFS_CHANNEL_MODE: s_d.ch_mode = wdata_i; // see RULE_07
				OFS_IRQ_LEVEL_A: s_d.irq_a = wdata_i & IRQA_MASK; // see RULE_09
				OFS_IRQ_LEVEL_B: s_d.irq_b = wdata_i; // see RULE_10
				OFS_RUN_SET:
				begin
					s_d.run = s_d.run | (wdata_i & RUN_MASK); // see RULE_11
					s_d.cmd = wcmd; // see RULE_16
				end
				OFS_RUN_CLEAR:
				begin
					// see RULE_20, RULE_25
					s_d.run = s_d.run & ~(wdata_i & RUN_MASK); // see RULE_11
				end
				default: s_d.cmd = CMD_NONE;
			endcase
		end
	end

	// single register bank
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_q <= '0;
			s_q.run <= RUN_RESET; // see RULE_13
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// outputs to the counter datapath
	assign count_run_o = ~s_q.run[STOP_BIT] & (s_q.clk_sel != CLOCK_SOURCE_SELECT_OFF); // see RULE_14, RULE_23
	assign events_enable_o = ~s_q.run[STOP_BIT]; // see RULE_13
	assign cc_event_o = s_q.run[STOP_BIT] ? 4'h0 : s_q.cc_ev;
	assign restart_event_o = s_q.rst_ev & ~s_q.run[STOP_BIT];
	assign restart_src_o = rsrc;
	assign event_action_o = s_q.routing[EVENT_ACTION_SELECT_LSB +: 3];
	assign channel_mode_o = s_q.ch_mode;
	assign count_dir_o = s_q.run[DIR_BIT];
	// capture makes the lock irrelevant
	assign update_allow_o = ~s_q.run[UPDATE_LOCK_BIT] | capture_any_i; // see RULE_17, RULE_18
	assign cmd_update_o = (s_q.cmd == CMD_UPDATE); // see RULE_15
	assign cmd_restart_o = (s_q.cmd == CMD_RESTART);
	// hard reset only honoured while counter is off
	assign cmd_hard_reset_o = (s_q.cmd == CMD_HARD_RESET) & counter_off_i; // see RULE_15
	// level 00 disables, others pass priority on; see RULE_24
	assign restart_irq_level_o = s_q.irq_a[5:4];
	assign error_irq_level_o = s_q.irq_a[3:2];
	assign overflow_irq_level_o = s_q.irq_a[1:0];
	assign channel_irq_level_o = s_q.irq_b;
	assign rdata_o = s_q.rdata;
endmodule
`default_nettype wire

// File: verif/tec_props_properties.sv
// Purpose: port assertions for the control block
// Assumes: one clock, async active low reset
// Notes: bound to every tec_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module tec_props
	import tec_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic counter_off_i,
	input wire logic capture_any_i,
	input wire logic [3:0] cc_event_o,
	input wire logic events_enable_o,
	input wire logic count_dir_o,
	input wire logic update_allow_o,
	input wire logic cmd_restart_o,
	input wire logic cmd_hard_reset_o,
	input wire logic [1:0] overflow_irq_level_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// alias writes, the first step of every software run register change
	sequence s_set; wr_i && addr_i == OFS_RUN_SET; endsequence
	sequence s_clr; wr_i && addr_i == OFS_RUN_CLEAR; endsequence
	property p_cmd_rd; rd_i && addr_i[5:1] == 5'h04 |=> !rdata_o[3:2]; endproperty
	a_cmd_rd: assert property (p_cmd_rd) else $error("command bits read");
	property p_rst; s_set ##0 wdata_i[3:2] == 2'h2 |=> cmd_restart_o; endproperty
	a_rst: assert property (p_rst) else $error("no restart pulse");
	property p_hard;
		s_set ##0 wdata_i[3:2] == 2'h3 |=> cmd_hard_reset_o == $past(counter_off_i);
	endproperty
	a_hard: assert property (p_hard) else $error("hard reset gating");
	property p_stop; s_set ##0 wdata_i[5] |=> !events_enable_o; endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");
	property p_go; s_clr ##0 wdata_i[5] |=> events_enable_o; endproperty
	a_go: assert property (p_go) else $error("stop not cleared");
	property p_dir; s_set ##0 wdata_i[0] |=> count_dir_o; endproperty
	a_dir: assert property (p_dir) else $error("direction set lost");
	property p_dirc; s_clr ##0 wdata_i[0] |=> !count_dir_o; endproperty
	a_dirc: assert property (p_dirc) else $error("direction clear lost");
	property p_lock; capture_any_i |-> update_allow_o; endproperty
	a_lock: assert property (p_lock) else $error("lock during capture");
	property p_quiet; !events_enable_o [*2] |-> cc_event_o == 4'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("event while stopped");
	property p_lvl;
		wr_i && addr_i == OFS_IRQ_LEVEL_A |=> overflow_irq_level_o == $past(wdata_i[1:0]);
	endproperty
	a_lvl: assert property (p_lvl) else $error("overflow level wrong");
endmodule
bind tec_ctrl tec_props tec_props_i (.clk_i, .rst_n_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .counter_off_i, .capture_any_i, .cc_event_o,
	.events_enable_o, .count_dir_o, .update_allow_o, .cmd_restart_o,
	.cmd_hard_reset_o, .overflow_irq_level_o);
`default_nettype wire

// File: verif/tec_evt_src.sv
// Purpose: event routing network model feeding the channels
// Assumes: events are single-cycle pulses
// Notes: idle channels sit low, as the routing drives them
`timescale 1ns/10ps
`default_nettype none
module tec_evt_src
(
	input wire logic clk_i,
	input wire logic fire_i,
	input wire logic [2:0] ch_i,
	output logic [7:0] event_ch_o
);
	// one channel pulses for one cycle per request
	always_ff @(posedge clk_i)
	begin
		event_ch_o <= fire_i ? 8'h01 << ch_i : 8'h00;
	end
endmodule
`default_nettype wire

// File: verif/tec_ctrl_tb.sv
// Purpose: self-checking bench for the control block
// Assumes: registers read one cycle after the strobe
// Notes: random values from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module tec_ctrl_tb;
	import tec_pkg::*;
	logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, fire = 0;
	logic fa = 0, fb = 0, hs = 0, hv = 0, off = 0, cap = 0;
	logic [5:0] addr_i = 0;
	logic [7:0] wdata_i = 0, rdata_o, ev, d, run_m;
	logic [3:0] cc;
	logic [2:0] fch = 0, n, rsrc, act;
	logic run_o, en_o, upd_o, cu, cr, ch, rse, cd;
	logic [7:0] cm, cil;
	logic [1:0] ri, ei, oi;
	logic [2:0] rs_m [0:7] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h2, 3'h3, 3'h3,
		3'h4};
	int num_errors = 0, n_checks = 0, cyc = 0;
	always #2.5 clk_i = ~clk_i;
	tec_evt_src tec_evt_src_i (.clk_i(clk_i), .fire_i(fire), .ch_i(fch),
		.event_ch_o(ev));
	tec_ctrl tec_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.event_ch_i(ev), .fault_input_a_i(fa), .fault_input_b_i(fb),
		.hw_dir_set_i(hs), .hw_dir_value_i(hv), .counter_off_i(off),
		.capture_any_i(cap), .cc_event_o(cc), .restart_event_o(rse),
		.restart_src_o(rsrc), .event_action_o(act), .channel_mode_o(cm),
		.count_run_o(run_o), .events_enable_o(en_o), .count_dir_o(cd),
		.update_allow_o(upd_o), .cmd_update_o(cu), .cmd_restart_o(cr),
		.cmd_hard_reset_o(ch), .restart_irq_level_o(ri),
		.error_irq_level_o(ei), .overflow_irq_level_o(oi),
		.channel_irq_level_o(cil));
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(logic [7:0] s, logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// h pulses the hardware direction load beside the write
	task automatic wr(logic [5:0] a, logic [7:0] v, logic h = 0);
		@(posedge clk_i);
		wr_i <= 1;
		addr_i <= a;
		wdata_i <= v;
		hs <= h;
		@(posedge clk_i);
		wr_i <= 0;
		hs <= 0;
		#1;
	endtask
	task automatic rd(logic [5:0] a, logic [7:0] e);
		@(posedge clk_i);
		rd_i <= 1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 0;
		#1 chk(rdata_o, e);
	endtask
	// channel sources per action; faults override, pulse width doubles n
	function automatic logic [3:0] exp_cc(logic [2:0] a, logic [2:0] b,
		logic [7:0] e, logic x, logic y);
		logic [3:0] r;
		for (int k = 0; k < 4; k++)
			r[k] = e[3'(b + k)];
		if (a == 3'h1)
			r[1:0] = {2{x | y}};
		if (a == 3'h2)
			r = {y, x, y, x};
		if (a == 3'h6)
			r[1] = e[b];
		if (a == 3'h7)
			r = 4'h0;
		return r;
	endfunction
	// hang guard, generous for the short sequence below
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			stop_test;
		end
	end
	initial
	begin
		void'($urandom(32'hf0a9));
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1;
		rd(OFS_RUN_CLEAR, RUN_RESET);
		rd(6'h3e, 8'h00);
		// modes kept to 01/10, the fault unit being absent
		repeat (8)
		begin
			d = $urandom & 8'h55;
			d = d | ((~d & 8'h55) << 1);
			wr(OFS_CHANNEL_MODE, d);
			chk(cm, d);
			rd(OFS_CHANNEL_MODE, d);
			wr(OFS_IRQ_LEVEL_B, d);
			chk(cil, d);
			rd(OFS_IRQ_LEVEL_B, d);
			d = $urandom;
			wr(OFS_IRQ_LEVEL_A, d);
			chk({ri, ei, oi}, d & IRQA_MASK);
			rd(OFS_IRQ_LEVEL_A, d & IRQA_MASK);
		end
		$display("register test done");
		run_m = RUN_RESET;
		repeat (16)
		begin
			d = $urandom & 8'h23;
			if ($urandom % 2)
			begin
				wr(OFS_RUN_SET, d);
				run_m = run_m | d;
			end
			else
			begin
				wr(OFS_RUN_CLEAR, d);
				run_m = run_m & ~d;
			end
			rd(OFS_RUN_SET, run_m);
			rd(OFS_RUN_CLEAR, run_m);
		end
		for (int c = 1; c < 4; c++)
		begin
			off <= $urandom;
			wr(OFS_RUN_SET, 8'(c << 2));
			chk({cu, cr, ch}, {c == 1, c == 2, c == 3 && off});
			rd(OFS_RUN_SET, run_m);
		end
		hv <= 1;
		wr(6'h3e, 8'h00, 1);
		chk(cd, 1);
		rd(OFS_RUN_SET, run_m | 8'h01);
		wr(OFS_RUN_CLEAR, 8'h01, 1);
		chk(cd, 0);
		rd(OFS_RUN_SET, run_m & 8'hfe);
		$display("alias test done");
		wr(OFS_CLOCK_SOURCE, 8'h05);
		wr(OFS_RUN_CLEAR, 8'h20);
		wr(OFS_RUN_SET, 8'h02);
		chk({run_o, en_o, upd_o}, 3'b110);
		cap <= 1;
		#1 chk(upd_o, 1);
		wr(OFS_CLOCK_SOURCE, 8'h00);
		chk({run_o, en_o}, 2'b01);
		wr(OFS_CHANNEL_MODE, 8'haa);
		for (int a = 0; a < 8; a++)
		begin
			n = $urandom;
			fa <= $urandom;
			fb <= $urandom;
			d = {3'(a), 1'($urandom), 1'b1, n};
			wr(OFS_EVENT_ROUTING, d);
			chk({rsrc, act}, {rs_m[a], 3'(a)});
			fch <= 3'($urandom);
			fire <= 1;
			@(posedge clk_i);
			fire <= 0;
			repeat (1 + d[4]) @(posedge clk_i);
			#1 chk(cc, exp_cc(a, n, ev | (8'h01 << fch), fa, fb));
			chk(rse, (a == 5 || a == 6) && fch == n);
		end
		wr(OFS_RUN_SET, 8'h20);
		chk({run_o, en_o}, 2'b00);
		$display("routing test done");
		stop_test;
	end
endmodule
`default_nettype wire
